// ### design/bcsu_defs.vh
// constants for the branch, compare and skip unit
`ifndef BCSU_DEFS_VH
`define BCSU_DEFS_VH
// operation codes on opSel
`define BCSU_OP_NONE        5'h00
`define BCSU_OP_INDIRECT_SUBROUTINE_JUMP_Z     5'h01
`define BCSU_OP_CALL_K      5'h02
`define BCSU_OP_SUB_EXIT    5'h03
`define BCSU_OP_INT_EXIT    5'h04
`define BCSU_OP_CMP_SKIP_EQ 5'h05
`define BCSU_OP_REG_CMP     5'h06
`define BCSU_OP_CMP_BORROW  5'h07
`define BCSU_OP_CMP_IMM     5'h08
`define BCSU_OP_SKIP_RB_CLR 5'h09
`define BCSU_OP_SKIP_RB_SET 5'h0A
`define BCSU_OP_SKIP_IO_CLR 5'h0B
`define BCSU_OP_SKIP_IO_SET 5'h0C
`define BCSU_OP_BR_FLAG_SET 5'h0D
`define BCSU_OP_BR_FLAG_CLR 5'h0E
`define BCSU_OP_BR_EQ       5'h0F
`define BCSU_OP_BR_NE       5'h10
`define BCSU_OP_BR_CS       5'h11
`define BCSU_OP_BR_CC       5'h12
`define BCSU_OP_BR_SH       5'h13
`define BCSU_OP_BR_LO       5'h14
`define BCSU_OP_BR_NEG      5'h15
`define BCSU_OP_BR_IE       5'h16
`define BCSU_OP_BR_ID       5'h17
// status flag bit positions
`define BCSU_FLG_C 0
`define BCSU_FLG_Z 1
`define BCSU_FLG_N 2
`define BCSU_FLG_V 3
`define BCSU_FLG_S 4
`define BCSU_FLG_H 5
`define BCSU_FLG_I 7
// cycle counts
`define BCSU_CYC_INDIRECT_SUBROUTINE_JUMP  3'h3
`define BCSU_CYC_CALL   3'h4
`define BCSU_CYC_RETURN 3'h4
`define BCSU_CYC_ONE    3'h1
`define BCSU_CYC_TWO    3'h2
`define BCSU_CYC_THREE  3'h3
// skip distances over a one-word and a two-word instruction
`define BCSU_SKIP_SHORT 2'h2
`define BCSU_SKIP_LONG  2'h3
// reset values
`define BCSU_PC_RESET    16'h0000
`define BCSU_FLAGS_RESET 8'h00
`endif

// ### design/bcsu_branch_compare_skip_unit.v
// branch, compare and skip execution unit of an 8-bit core
`timescale 1ns/10ps
`include "bcsu_defs.vh"
module bcsu_branch_compare_skip_unit #(
    parameter PC_W = 16                     // program counter width
) (
    input  wire            clk,             // core clock
    input  wire            resetn,          // async reset, active low
    input  wire            start,           // opSel valid, one-cycle pulse
    input  wire [4:0]      opSel,           // operation code
    input  wire [7:0]      rdVal,           // Rd value
    input  wire [7:0]      rrVal,           // Rr value or immediate K
    input  wire [7:0]      ioVal,           // I/O register P value
    input  wire [2:0]      bitSel,          // bit b or flag s
    input  wire [6:0]      relK,            // signed relative offset
    input  wire [PC_W-1:0] absK,            // absolute call target
    input  wire [PC_W-1:0] zPtr,            // Z pointer
    input  wire [PC_W-1:0] stackPc,         // PC popped from stack
    input  wire [PC_W-1:0] curPc,           // address of this instruction
    input  wire            nextIsLong,      // following instruction is two words
    input  wire [7:0]      flagsIn,         // status_flags from core
    output reg  [PC_W-1:0] newPc,           // next PC
    output reg             pcLoad,          // newPc valid, one-cycle pulse
    output reg  [7:0]      flagsOut,        // updated status_flags
    output reg             flagsWe,         // flagsOut valid, one-cycle pulse
    output reg             busy,            // unit executing
    output reg             done             // last cycle of instruction
);
    localparam ST_IDLE = 1'b0;
    localparam ST_WAIT = 1'b1;
    // ST_WAIT covers every cycle between issue and completion

    reg             state_q;
    reg [2:0]       cnt_q;
    reg [PC_W-1:0]  pcHold_q;
    reg [7:0]       flagHold_q;
    reg             flagHoldWe_q;

    // combinational evaluation of the issued operation
    reg [PC_W-1:0]  tgt;
    reg [7:0]       flg;
    reg             flgWe;
    reg [2:0]       cyc;
    reg [7:0]       subB;
    reg             subCin;
    reg [8:0]       diff;
    reg             cond;
    reg             isSub;
    wire [PC_W-1:0] seqPc  = curPc + {{(PC_W-1){1'b0}}, 1'b1};
    // skip distance follows the length of the instruction stepped over
    wire [1:0]      skipDist = nextIsLong ? `BCSU_SKIP_LONG : `BCSU_SKIP_SHORT;
    wire [PC_W-1:0] skipPc = curPc + {{(PC_W-2){1'b0}}, skipDist};
    // operation classes; a taken branch takes 2 cycles, like a skip over a one-word instruction
    wire            isSkipOp = (opSel >= `BCSU_OP_CMP_SKIP_EQ) && (opSel <= `BCSU_OP_SKIP_IO_SET);
    wire            isBrOp   = (opSel >= `BCSU_OP_BR_FLAG_SET) && (opSel <= `BCSU_OP_BR_ID);
    // tested bits picked once, shared by the bit-test skips and every branch
    wire            regBit   = rrVal[bitSel];
    wire            ioBit    = ioVal[bitSel];
    wire            flagBit  = flagsIn[bitSel];
    wire            zFlag    = flagsIn[`BCSU_FLG_Z];
    wire            cFlag    = flagsIn[`BCSU_FLG_C];
    wire            nFlag    = flagsIn[`BCSU_FLG_N];
    wire            iFlag    = flagsIn[`BCSU_FLG_I];
    // sign extension lets branches reach backwards
    wire [PC_W-1:0] relPc  = seqPc + {{(PC_W-7){relK[6]}}, relK};

    always @* begin
        tgt    = seqPc;
        flg    = flagsIn;
        flgWe  = 1'b0;
        cyc    = `BCSU_CYC_ONE;
        cond   = 1'b0;
        isSub  = 1'b0;
        subB   = rrVal;
        subCin = 1'b0;
        diff   = 9'h000;
        case (opSel)
            `BCSU_OP_INDIRECT_SUBROUTINE_JUMP_Z: begin
                tgt = zPtr;
                cyc = `BCSU_CYC_INDIRECT_SUBROUTINE_JUMP;
            end
            `BCSU_OP_CALL_K: begin
                tgt = absK;
                cyc = `BCSU_CYC_CALL;
            end
            `BCSU_OP_SUB_EXIT: begin
                tgt = stackPc;
                cyc = `BCSU_CYC_RETURN;
            end
            `BCSU_OP_INT_EXIT: begin
                tgt = stackPc;
                cyc = `BCSU_CYC_RETURN;
                // only I is forced; the other flags pass through
                flg[`BCSU_FLG_I] = 1'b1;
                flgWe = 1'b1;
            end
            `BCSU_OP_CMP_SKIP_EQ: cond = (rdVal == rrVal);
            `BCSU_OP_SKIP_RB_CLR: cond = ~regBit;
            `BCSU_OP_SKIP_RB_SET: cond = regBit;
            `BCSU_OP_SKIP_IO_CLR: cond = ~ioBit;
            `BCSU_OP_SKIP_IO_SET: cond = ioBit;
            `BCSU_OP_REG_CMP: isSub = 1'b1;
            `BCSU_OP_CMP_IMM: isSub = 1'b1;
            `BCSU_OP_CMP_BORROW: begin
                isSub  = 1'b1;
                subCin = cFlag;
            end
            `BCSU_OP_BR_FLAG_SET: cond = flagBit;
            `BCSU_OP_BR_FLAG_CLR: cond = ~flagBit;
            `BCSU_OP_BR_EQ:       cond = zFlag;
            `BCSU_OP_BR_NE:       cond = ~zFlag;
            `BCSU_OP_BR_CS:       cond = cFlag;
            `BCSU_OP_BR_LO:       cond = cFlag;
            `BCSU_OP_BR_CC:       cond = ~cFlag;
            `BCSU_OP_BR_SH:       cond = ~cFlag;
            `BCSU_OP_BR_NEG:      cond = nFlag;
            `BCSU_OP_BR_IE:       cond = iFlag;
            `BCSU_OP_BR_ID:       cond = ~iFlag;
            // unknown codes step on by one word like a plain instruction
            default: cyc = `BCSU_CYC_ONE;
        endcase
        // skips: 1 cycle, 2 over a one-word, 3 over a two-word instruction
        if (isSkipOp && !isSub && cond) begin
            tgt = skipPc;
            cyc = nextIsLong ? `BCSU_CYC_THREE : `BCSU_CYC_TWO;
        end
        if (isBrOp && cond) begin
            tgt = relPc;
            cyc = `BCSU_CYC_TWO;
        end
        // compares write flags only; the difference itself is dropped
        if (isSub) begin
            diff = {1'b0, rdVal} - {1'b0, subB} - {8'h00, subCin};
            flg[`BCSU_FLG_C] = diff[8];
            flg[`BCSU_FLG_N] = diff[7];
            flg[`BCSU_FLG_V] = (rdVal[7] & ~subB[7] & ~diff[7]) |
                               (~rdVal[7] & subB[7] & diff[7]);
            flg[`BCSU_FLG_H] = (~rdVal[3] & subB[3]) | (subB[3] & diff[3]) |
                               (diff[3] & ~rdVal[3]);
            flg[`BCSU_FLG_S] = diff[7] ^ flg[`BCSU_FLG_V];
            // with borrow, Z only stays set; multi-byte compares chain this way
            if (opSel == `BCSU_OP_CMP_BORROW)
                flg[`BCSU_FLG_Z] = (diff[7:0] == 8'h00) & flagsIn[`BCSU_FLG_Z];
            else
                flg[`BCSU_FLG_Z] = (diff[7:0] == 8'h00);
            flgWe = 1'b1;
        end
    end

    // results come out on the last cycle so pcLoad marks completion
    always @(posedge clk or negedge resetn) begin
        // outputs clear at once so a cut operation leaves no strobe behind
        if (!resetn) begin
            state_q      <= ST_IDLE;
            cnt_q        <= 3'h0;
            pcHold_q     <= `BCSU_PC_RESET;
            flagHold_q   <= `BCSU_FLAGS_RESET;
            flagHoldWe_q <= 1'b0;
            newPc        <= `BCSU_PC_RESET;
            pcLoad       <= 1'b0;
            flagsOut     <= `BCSU_FLAGS_RESET;
            flagsWe      <= 1'b0;
            busy         <= 1'b0;
            done         <= 1'b0;
        end else begin
            pcLoad  <= 1'b0;
            flagsWe <= 1'b0;
            done    <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (start) begin
                        // one-cycle operations finish here; longer ones park the result
                        if (cyc == `BCSU_CYC_ONE) begin
                            newPc    <= tgt;
                            pcLoad   <= 1'b1;
                            flagsOut <= flg;
                            flagsWe  <= flgWe;
                            done     <= 1'b1;
                        end else begin
                            pcHold_q     <= tgt;
                            flagHold_q   <= flg;
                            flagHoldWe_q <= flgWe;
                            // neither the issue edge nor the done edge is counted
                            cnt_q        <= cyc - 3'h2;
                            busy         <= 1'b1;
                            state_q      <= ST_WAIT;
                        end
                    end
                end
                ST_WAIT: begin
                    // start is not looked at here, so a request while busy is dropped
                    if (cnt_q == 3'h0) begin
                        newPc    <= pcHold_q;
                        pcLoad   <= 1'b1;
                        flagsOut <= flagHold_q;
                        flagsWe  <= flagHoldWe_q;
                        done     <= 1'b1;
                        busy     <= 1'b0;
                        state_q  <= ST_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 3'h1;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end
endmodule // bcsu_branch_compare_skip_unit

// ### tb/bcsu_unit_asserts.sv
// assertion checker bound to the branch compare skip unit
`timescale 1ns/10ps
`include "bcsu_defs.vh"
module bcsu_unit_asserts #(
    parameter PC_W = 16
) (
    input wire            clk,      // core clock
    input wire            resetn,   // async reset
    input wire            start,    // issue strobe
    input wire [4:0]      opSel,    // operation
    input wire [6:0]      relK,     // branch offset
    input wire [PC_W-1:0] absK,     // call target
    input wire [PC_W-1:0] zPtr,     // Z pointer
    input wire [PC_W-1:0] stackPc,  // popped PC
    input wire [PC_W-1:0] curPc,    // issued address
    input wire [7:0]      flagsIn,  // flags in
    input wire [PC_W-1:0] newPc,    // next PC
    input wire            pcLoad,   // PC strobe
    input wire [7:0]      flagsOut, // flags out
    input wire            flagsWe,  // flag strobe
    input wire            busy,     // executing
    input wire            done      // completion
);
    wire            take   = start && !busy;
    // targets are formed at issue time since operands may move later
    wire [PC_W-1:0] brTgt  = curPc + {{(PC_W-7){relK[6]}}, relK} + 1'b1;
    wire [PC_W-1:0] pcNext = curPc + 1'b1;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_busy3; busy [*3]; endsequence
    AST_INDIRECT_SUBROUTINE_JUMP: assert property (take && opSel == `BCSU_OP_INDIRECT_SUBROUTINE_JUMP_Z
        |-> ##3 done && newPc == $past(zPtr, 3)) else $error("indirect call wrong");
    AST_CALL: assert property (take && opSel == `BCSU_OP_CALL_K
        |-> ##1 s_busy3 ##1 (done && newPc == $past(absK, 4))) else $error("call wrong");
    AST_RET: assert property (take && opSel == `BCSU_OP_SUB_EXIT
        |-> ##4 done && !flagsWe && newPc == $past(stackPc, 4)) else $error("exit wrong");
    AST_INTERRUPT_EXIT: assert property (take && opSel == `BCSU_OP_INT_EXIT
        |-> ##4 done && flagsWe && flagsOut[7]) else $error("interrupt exit wrong");
    AST_CMP: assert property (take && opSel inside {[6:8]}
        |-> ##1 done && flagsWe && newPc == $past(pcNext)) else $error("compare wrong");
    AST_BR_TAKEN: assert property (take && opSel == `BCSU_OP_BR_EQ && flagsIn[1]
        |-> ##1 !done ##1 done && newPc == $past(brTgt, 2)) else $error("branch target wrong");
    AST_BR_FALL: assert property (take && opSel == `BCSU_OP_BR_NE && flagsIn[1]
        |-> ##1 done && newPc == $past(pcNext)) else $error("fall through wrong");
    AST_BR_MINUS: assert property (take && opSel == `BCSU_OP_BR_NEG && !flagsIn[2]
        |-> ##1 done && !flagsWe) else $error("minus branch wrong");
    AST_BR_IRQ: assert property (take && opSel == `BCSU_OP_BR_IE && flagsIn[7]
        |-> ##2 done && newPc == $past(brTgt, 2)) else $error("irq branch wrong");
endmodule // bcsu_unit_asserts
bind bcsu_branch_compare_skip_unit bcsu_unit_asserts #(.PC_W(PC_W)) u_chk (
    .clk(clk), .resetn(resetn), .start(start), .opSel(opSel), .relK(relK), .absK(absK),
    .zPtr(zPtr), .stackPc(stackPc), .curPc(curPc), .flagsIn(flagsIn), .newPc(newPc),
    .pcLoad(pcLoad), .flagsOut(flagsOut), .flagsWe(flagsWe), .busy(busy), .done(done));

// ### tb/tb_branch_compare_skip_unit.sv
// self-checking bench for the branch compare skip unit
`timescale 1ns/10ps
`include "bcsu_defs.vh"
`define CHK(a, b, m) begin samplesChecked++; if ((a) !== (b)) begin failCount++; \
    $display("CHECK FAILED %0t %s", $time, m); end end
module tb_branch_compare_skip_unit;
    reg        clk = 1'b0, resetn = 1'b0, start = 1'b0, nextIsLong = 1'b0;
    reg [4:0]  opSel = 5'h00;
    reg [7:0]  rdVal = 8'h00, rrVal = 8'h00, ioVal = 8'h00, flagsIn = 8'h00, expFl;
    reg [2:0]  bitSel = 3'h0;
    reg [6:0]  relK = 7'h00;
    reg [15:0] absK = 16'h0000, zPtr = 16'h0000, stackPc = 16'h0000, curPc = 16'h0000;
    reg [15:0] expPc;
    reg [8:0]  d;
    reg        cond, expWe;
    wire [15:0] newPc;
    wire [7:0]  flagsOut;
    wire        pcLoad, flagsWe, busy, done;
    integer    failCount = 0, samplesChecked = 0, n, expCyc, op, i;
    always #2.5 clk = ~clk;
    bcsu_branch_compare_skip_unit u_bcsu_branch_compare_skip_unit (
        .clk(clk), .resetn(resetn), .start(start), .opSel(opSel), .rdVal(rdVal),
        .rrVal(rrVal), .ioVal(ioVal), .bitSel(bitSel), .relK(relK), .absK(absK),
        .zPtr(zPtr), .stackPc(stackPc), .curPc(curPc), .nextIsLong(nextIsLong),
        .flagsIn(flagsIn), .newPc(newPc), .pcLoad(pcLoad), .flagsOut(flagsOut),
        .flagsWe(flagsWe), .busy(busy), .done(done));
    task printVerdict;
        begin
            $display("checks %0d failures %0d", samplesChecked, failCount);
            if (failCount == 0 && samplesChecked > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    task model;
        begin
            expPc = curPc + 16'h0001; expCyc = 1; expWe = 0; expFl = flagsIn; cond = 0;
            case (opSel)
            `BCSU_OP_INDIRECT_SUBROUTINE_JUMP_Z: begin expPc = zPtr; expCyc = 3; end
            `BCSU_OP_CALL_K: begin expPc = absK; expCyc = 4; end
            `BCSU_OP_SUB_EXIT: begin expPc = stackPc; expCyc = 4; end
            `BCSU_OP_INT_EXIT: begin expPc = stackPc; expCyc = 4; expWe = 1; expFl[7] = 1; end
            `BCSU_OP_CMP_SKIP_EQ: cond = rdVal == rrVal;
            `BCSU_OP_REG_CMP, `BCSU_OP_CMP_BORROW, `BCSU_OP_CMP_IMM: begin
                d = {1'b0, rdVal} - rrVal - (opSel == `BCSU_OP_CMP_BORROW && flagsIn[0]);
                expWe = 1;
                expFl[0] = d[8];
                expFl[1] = d[7:0] == 8'h00 && (opSel != `BCSU_OP_CMP_BORROW || flagsIn[1]);
                expFl[2] = d[7];
                expFl[3] = (rdVal[7] ^ rrVal[7]) & (rdVal[7] ^ d[7]);
                expFl[4] = d[7] ^ expFl[3];
                expFl[5] = (!rdVal[3] & rrVal[3]) | (rrVal[3] & d[3]) | (d[3] & !rdVal[3]);
            end
            `BCSU_OP_SKIP_RB_CLR: cond = !rrVal[bitSel];
            `BCSU_OP_SKIP_RB_SET: cond = rrVal[bitSel];
            `BCSU_OP_SKIP_IO_CLR: cond = !ioVal[bitSel];
            `BCSU_OP_SKIP_IO_SET: cond = ioVal[bitSel];
            `BCSU_OP_BR_FLAG_SET: cond = flagsIn[bitSel];
            `BCSU_OP_BR_FLAG_CLR: cond = !flagsIn[bitSel];
            `BCSU_OP_BR_EQ: cond = flagsIn[1];
            `BCSU_OP_BR_NE: cond = !flagsIn[1];
            `BCSU_OP_BR_CS, `BCSU_OP_BR_LO: cond = flagsIn[0];
            `BCSU_OP_BR_CC, `BCSU_OP_BR_SH: cond = !flagsIn[0];
            `BCSU_OP_BR_NEG: cond = flagsIn[2];
            `BCSU_OP_BR_IE: cond = flagsIn[7];
            `BCSU_OP_BR_ID: cond = !flagsIn[7];
            default: cond = 0;
            endcase
            if (cond && opSel < `BCSU_OP_BR_FLAG_SET) begin
                expPc = curPc + 16'h0002 + nextIsLong;
                expCyc = 2 + nextIsLong;
            end else if (cond) begin
                expPc = curPc + {{9{relK[6]}}, relK} + 16'h0001;
                expCyc = 2;
            end
        end
    endtask
    // poke raises a second start while busy, which must be ignored
    task issue(input reg poke);
        begin
            model;
            start = 1'b1;
            n = 0;
            do begin
                @(negedge clk);
                n = n + 1;
                if (!done) start = poke && n == 1;
                if (!done && poke && n == 1) opSel = `BCSU_OP_BR_EQ;
                if (!done) `CHK(busy, 1'b1, "busy while waiting")
            end while (!done && n < 9);
            if (!done) begin
                failCount++;
                $display("CHECK FAILED %0t timeout waiting for done", $time);
                printVerdict;
            end
            `CHK(n, expCyc, "cycle count")
            `CHK(busy, 1'b0, "busy after done")
            `CHK(newPc, expPc, "next pc")
            `CHK(pcLoad, 1'b1, "pc strobe")
            `CHK(flagsWe, expWe, "flag strobe")
            if (expWe) `CHK(flagsOut, expFl, "flags")
        end
    endtask
    initial begin
        i = $urandom(32'hC1D78695);
        repeat (4) @(negedge clk);
        resetn = 1'b1;
        `CHK(pcLoad | busy | done | flagsWe, 1'b0, "reset state")
        for (i = 0; i < 480; i = i + 1) begin
            op = i % 24;
            opSel = op[4:0];
            {rdVal, rrVal, ioVal, flagsIn} = $urandom;
            if (i % 3 == 0) rrVal = rdVal;
            {bitSel, relK, nextIsLong} = $urandom;
            {absK, zPtr} = $urandom;
            {stackPc, curPc} = $urandom;
            issue(op == 2 && i % 2 == 1);
            if (i % 24 == 23) $display("opcode sweep %0d finished", i / 24);
        end
        // reset in the middle of a direct call must drop the pending result
        opSel = `BCSU_OP_CALL_K;
        start = 1'b1;
        @(negedge clk);
        `CHK(busy, 1'b1, "call accepted")
        start = 1'b0;
        resetn = 1'b0;
        @(negedge clk);
        `CHK({pcLoad, busy, done, flagsWe, flagsOut, newPc}, 28'h0000000, "mid reset")
        resetn = 1'b1;
        opSel = `BCSU_OP_BR_EQ;
        issue(1'b0);
        $display("mid-run reset test finished");
        printVerdict;
    end
endmodule // tb_branch_compare_skip_unit
